// ### hdl/tslc_defs.svh
// register indices, reset values, field positions and limits of the touch sleep/lid block
// Functional notes
// RULE1 - sleep select register picks inputs sampled in sleep; bit 7 group; resets unsampled
// RULE2 - group sleep bit samples group in sleep; gestures set status and interrupt
// RULE3 - sensor sleep bit samples that input in sleep; touch sets status and interrupt
// RULE4 - host should recalibrate newly activated channels after changing selection in sleep
// RULE5 - selection change in sleep may lengthen first conversion of newly added sensors only
// RULE6 - blocking enabled by default accepts touches up to limit, holds valid ones
// RULE7 - blocking disabled passes every simultaneous touch
// RULE8 - button limit codes 0 to 3 give 1 to 4 touches; resets 00
// RULE9 - multiple touch event when touched count in a set exceeds its limit
// RULE10 - group limit codes 0 to 3 give 2 to 5 touches; resets 10
// RULE11 - lid detect enable resets off; when on, status and patterns judge closure
// RULE12 - match method clear compares counts of status and pattern bits
// RULE13 - match method set needs every pattern bit present in lid status
// RULE14 - lid event drives interrupt only with lid interrupt enable, reset clear
// RULE15 - lid status sets after queue depth consecutive samples; depth resets to two
// RULE16 - queue runs per sensor and governs both setting and clearing
// RULE17 - queue depth zero means one sample
// RULE18 - count mode fires on buttons, group, or combined counts reaching pattern counts
// RULE19 - every lid event sets a readable flag in group status
// RULE20 - unused bits of multi touch, lid config and queue read zero, ignore writes
`ifndef TSLC_DEFS_SVH
`define TSLC_DEFS_SVH

`define TSLC_IDX_SLEEP_SEL 8'h29
`define TSLC_IDX_MULTI 8'h2A
`define TSLC_IDX_LID_CFG 8'h2B
`define TSLC_IDX_QUEUE 8'h2C
`define TSLC_IDX_PAT1 8'h2D
`define TSLC_IDX_PAT2 8'h2E
`define TSLC_IDX_STATUS 8'h40
`define TSLC_IDX_GRP_STATUS 8'h41
`define TSLC_IDX_LID_STATUS 8'h42

`define TSLC_RST_SLEEP_SEL 8'h00
`define TSLC_RST_MULTI 8'h82
`define TSLC_RST_LID_CFG 8'h00
`define TSLC_RST_QUEUE 8'h02
`define TSLC_RST_PAT 8'h7F

`define TSLC_MASK_MULTI 8'h8F
`define TSLC_MASK_LID_CFG 8'h83
`define TSLC_MASK_QUEUE 8'h07
`define TSLC_MASK_PAT 8'h7F

`define TSLC_GRP_SLEEP_BIT 7
`define TSLC_BLK_EN_BIT 7
`define TSLC_BTN_LIM_LSB 2
`define TSLC_GRP_LIM_LSB 0
`define TSLC_LID_EN_BIT 7
`define TSLC_LID_MATCH_BIT 1
`define TSLC_LID_IRQ_BIT 0
`define TSLC_BTN_LIM_BASE 4'h1
`define TSLC_GRP_LIM_BASE 4'h2

`define TSLC_GS_LID_BIT 0
`define TSLC_GS_MT_BIT 1
`define TSLC_GS_GEST_LSB 2
`define TSLC_GS_GEST_MSB 4
`define TSLC_STAT_GRP_BIT 7

`endif

// ### hdl/tslc_lid_queue.sv
// per-sensor consecutive-sample filter for lid status
`timescale 1ns/1ps
`include "tslc_defs.svh"
module tslc_lid_queue #(
  parameter int NUM_SENSORS = 14
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // queue carrier
  tslc_queue_if.queue qif
);
  logic [3:0] need;

  // depth zero is treated as one sample
  assign need = (qif.depth == 3'h0) ? 4'h1 : {1'b0, qif.depth}; // [RULE17]

  genvar i;
  generate
    for (i = 0; i < NUM_SENSORS; i++)
    begin : g_sensor
      logic [2:0] cnt_r;
      logic stat_r;
      // count samples that disagree with the held status, flip when enough in a row
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          cnt_r <= 3'h0;
          stat_r <= 1'b0;
        end
        else if (qif.sample_strobe)
        begin
          if (qif.lid_raw[i] != stat_r)
          begin
            if ({1'b0, cnt_r} + 4'h1 >= need) // [RULE15] [RULE16]
            begin
              stat_r <= qif.lid_raw[i];
              cnt_r <= 3'h0;
            end
            else
            begin
              cnt_r <= cnt_r + 3'h1;
            end
          end
          else
          begin
            cnt_r <= 3'h0; // a break in the run restarts it
          end
        end
      end
      assign qif.lid_status[i] = stat_r;
    end
  endgenerate
endmodule : tslc_lid_queue

// ### hdl/tslc_pkg.sv
// shared types of the touch sleep/lid block
package tslc_pkg;
  typedef enum logic [1:0] {
    TSLC_RESP_OKAY = 2'h0,
    TSLC_RESP_SLVERR = 2'h2
  } tslc_resp_type;
  typedef logic [13:0] tslc_sensor_type;
  typedef logic [6:0] tslc_set_type;
endpackage : tslc_pkg

// ### hdl/tslc_queue_if.sv
// carrier between the control block and the per-sensor lid queue
`timescale 1ns/1ps
interface tslc_queue_if;
  logic [2:0] depth;
  logic sample_strobe;
  tslc_pkg::tslc_sensor_type lid_raw;
  tslc_pkg::tslc_sensor_type lid_status;
  modport ctrl (output depth, output sample_strobe, output lid_raw, input lid_status);
  modport queue (input depth, input sample_strobe, input lid_raw, output lid_status);
endinterface : tslc_queue_if

// ### hdl/tslc_top.sv
// touch sleep selection, multiple touch blocking and lid closure detection with AXI4-Lite registers
`timescale 1ns/1ps
`include "tslc_defs.svh"
module tslc_top #(
  parameter int ADDR_W = 12,
  parameter int NUM_SENSORS = 14,
  parameter int NUM_BUTTONS = 7
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sensing front end
  input wire logic sleep_mode,
  input wire logic sample_strobe,
  input wire logic [NUM_SENSORS-1:0] touch_raw,
  input wire logic [NUM_SENSORS-1:0] lid_raw,
  input wire logic [2:0] gesture_evt,
  // results
  output logic [NUM_SENSORS-1:0] sample_en,
  output logic [NUM_SENSORS-1:0] sample_extend,
  output logic [NUM_SENSORS-1:0] touch_accepted,
  output logic multi_touch_evt,
  output logic [NUM_SENSORS-1:0] lid_status,
  output logic alert
);
  localparam int NUM_GROUP = NUM_SENSORS - NUM_BUTTONS;

  // count set bits of one sensor set
  function automatic logic [3:0] popcnt(input logic [6:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int k = 0; k < 7; k++)
    begin
      c = c + {3'h0, v[k]};
    end
    return c;
  endfunction : popcnt

  // keep touches still held, then admit new ones in index order up to the limit
  function automatic logic [6:0] admit(input logic [6:0] touched, input logic [6:0] held, input logic [3:0] lim);
    logic [6:0] acc;
    logic [3:0] c;
    acc = touched & held;
    c = popcnt(acc);
    for (int k = 0; k < 7; k++)
    begin
      if (touched[k] && !acc[k] && (c < lim))
      begin
        acc[k] = 1'b1;
        c = c + 4'h1;
      end
    end
    return acc;
  endfunction : admit

  logic [7:0] sleep_sel_r;
  logic [7:0] multi_r;
  logic [7:0] lid_cfg_r;
  logic [7:0] queue_r;
  logic [7:0] pat1_r;
  logic [7:0] pat2_r;
  logic [7:0] touch_stat_r;
  logic [4:0] grp_stat_r;
  logic [NUM_SENSORS-1:0] extend_r;
  logic [NUM_SENSORS-1:0] accepted_r;
  logic mt_evt_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0] wdata_r;
  logic wlane0_r;
  logic bvalid_r;
  tslc_pkg::tslc_resp_type bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  tslc_pkg::tslc_resp_type rresp_r;
  logic do_write;
  logic [7:0] widx;
  logic [7:0] ridx;
  logic [7:0] wbyte;
  logic [31:0] rmux;
  logic rhit;
  logic whit;
  logic [3:0] btn_lim;
  logic [3:0] grp_lim;
  logic [6:0] btn_touch;
  logic [6:0] grp_touch;
  logic [NUM_SENSORS-1:0] sleep_cover;
  logic [NUM_SENSORS-1:0] sel_as_sensors;
  logic [NUM_SENSORS-1:0] new_sel;
  logic [NUM_SENSORS-1:0] touch_seen;
  logic lid_match;
  logic [3:0] st1_cnt;
  logic [3:0] st2_cnt;
  logic [3:0] p1_cnt;
  logic [3:0] p2_cnt;
  logic [4:0] st_tot;
  logic [4:0] p_tot;
  logic mt_now;

  tslc_queue_if qif ();

  // lid queue per sensor
  tslc_lid_queue #(
    .NUM_SENSORS(NUM_SENSORS)
  ) u_queue (
    .aclk(aclk),
    .aresetn(aresetn),
    .qif(qif)
  );

  assign qif.depth = queue_r[2:0];
  assign qif.sample_strobe = sample_strobe;
  assign qif.lid_raw = lid_raw;
  assign lid_status = qif.lid_status;

  // write channel handshakes and register index decode
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
  assign widx = waddr_r[9:2];
  assign ridx = s_axi_araddr[9:2];
  assign wbyte = wdata_r[7:0];
  assign whit = (waddr_r[ADDR_W-1:10] == '0) && ((widx >= `TSLC_IDX_SLEEP_SEL && widx <= `TSLC_IDX_PAT2) ||
    (widx >= `TSLC_IDX_STATUS && widx <= `TSLC_IDX_LID_STATUS));

  // address and data may arrive in either order, each held until the write is done
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= 32'h0;
      wlane0_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        waddr_r <= s_axi_awaddr;
      end
      else if (do_write)
      begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wlane0_r <= s_axi_wstrb[0];
      end
      else if (do_write)
      begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // write response, slave error for unmapped words
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= tslc_pkg::TSLC_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= whit ? tslc_pkg::TSLC_RESP_OKAY : tslc_pkg::TSLC_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // configuration registers, unused bits masked off
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sleep_sel_r <= `TSLC_RST_SLEEP_SEL; // [RULE1]
      multi_r <= `TSLC_RST_MULTI; // [RULE6] [RULE8] [RULE10]
      lid_cfg_r <= `TSLC_RST_LID_CFG; // [RULE11] [RULE12] [RULE14]
      queue_r <= `TSLC_RST_QUEUE; // [RULE15]
      pat1_r <= `TSLC_RST_PAT;
      pat2_r <= `TSLC_RST_PAT;
    end
    else if (do_write && wlane0_r)
    begin
      case (widx)
        `TSLC_IDX_SLEEP_SEL: sleep_sel_r <= wbyte; // [RULE1]
        `TSLC_IDX_MULTI: multi_r <= wbyte & `TSLC_MASK_MULTI; // [RULE20]
        `TSLC_IDX_LID_CFG: lid_cfg_r <= wbyte & `TSLC_MASK_LID_CFG; // [RULE20]
        `TSLC_IDX_QUEUE: queue_r <= wbyte & `TSLC_MASK_QUEUE; // [RULE20]
        `TSLC_IDX_PAT1: pat1_r <= wbyte & `TSLC_MASK_PAT;
        `TSLC_IDX_PAT2: pat2_r <= wbyte & `TSLC_MASK_PAT;
        default: ;
      endcase
    end
  end

  // sleep selection spread onto sensors: bits 6..0 buttons, bit 7 the whole group
  assign sel_as_sensors = {{NUM_GROUP{sleep_sel_r[`TSLC_GRP_SLEEP_BIT]}}, sleep_sel_r[6:0]};
  assign sample_en = sleep_mode ? sel_as_sensors : {NUM_SENSORS{1'b1}}; // [RULE1]
  assign new_sel = {{NUM_GROUP{wbyte[`TSLC_GRP_SLEEP_BIT]}}, wbyte[6:0]} & ~sel_as_sensors;

  // sensors added while asleep get one lengthened conversion, then run normally
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      extend_r <= '0;
    end
    else if (do_write && wlane0_r && widx == `TSLC_IDX_SLEEP_SEL && sleep_mode)
    begin
      extend_r <= (sample_strobe ? '0 : extend_r) | new_sel; // [RULE5]
    end
    else if (sample_strobe)
    begin
      extend_r <= '0; // [RULE5]
    end
  end
  assign sample_extend = extend_r;

  // touch limits decoded from the two fields
  assign btn_lim = {2'h0, multi_r[`TSLC_BTN_LIM_LSB+1:`TSLC_BTN_LIM_LSB]} + `TSLC_BTN_LIM_BASE; // [RULE8]
  assign grp_lim = {2'h0, multi_r[`TSLC_GRP_LIM_LSB+1:`TSLC_GRP_LIM_LSB]} + `TSLC_GRP_LIM_BASE; // [RULE10]
  assign btn_touch = touch_raw[6:0];
  assign grp_touch = touch_raw[NUM_SENSORS-1:NUM_BUTTONS];
  assign mt_now = (popcnt(btn_touch) > btn_lim) || (popcnt(grp_touch) > grp_lim); // [RULE9]

  // accepted touches update once per sample
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      accepted_r <= '0;
      mt_evt_r <= 1'b0;
    end
    else if (sample_strobe)
    begin
      mt_evt_r <= mt_now; // [RULE9]
      if (multi_r[`TSLC_BLK_EN_BIT])
      begin
        accepted_r <= {admit(grp_touch, accepted_r[NUM_SENSORS-1:NUM_BUTTONS], grp_lim),
          admit(btn_touch, accepted_r[6:0], btn_lim)}; // [RULE6]
      end
      else
      begin
        accepted_r <= touch_raw; // [RULE7]
      end
    end
    else
    begin
      mt_evt_r <= 1'b0;
    end
  end
  assign touch_accepted = accepted_r;
  assign multi_touch_evt = mt_evt_r;

  // lid closure judgement, by all pattern bits present in status or by counts
  assign st1_cnt = popcnt(lid_status[6:0]);
  assign st2_cnt = popcnt(lid_status[NUM_SENSORS-1:NUM_BUTTONS]);
  assign p1_cnt = popcnt(pat1_r[6:0]);
  assign p2_cnt = popcnt(pat2_r[6:0]);
  assign st_tot = {1'b0, st1_cnt} + {1'b0, st2_cnt};
  assign p_tot = {1'b0, p1_cnt} + {1'b0, p2_cnt};
  always_comb
  begin
    if (lid_cfg_r[`TSLC_LID_MATCH_BIT])
    begin
      lid_match = ((lid_status & {pat2_r[6:0], pat1_r[6:0]}) == {pat2_r[6:0], pat1_r[6:0]}); // [RULE13]
    end
    else
    begin
      lid_match = (st1_cnt >= p1_cnt) || (st2_cnt >= p2_cnt) || (st_tot >= p_tot); // [RULE12] [RULE18]
    end
  end

  // buttons whose touch may set status: all when awake, only selected in sleep
  assign sleep_cover = sample_en;
  assign touch_seen = sample_strobe ? (touch_raw & sleep_cover) : '0;

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      touch_stat_r <= 8'h00;
      grp_stat_r <= 5'h00;
    end
    else
    begin
      touch_stat_r[6:0] <= (touch_stat_r[6:0] & ~((do_write && wlane0_r && widx == `TSLC_IDX_STATUS) ?
        wbyte[6:0] : 7'h00)) | touch_seen[6:0]; // [RULE3]
      touch_stat_r[`TSLC_STAT_GRP_BIT] <= (touch_stat_r[`TSLC_STAT_GRP_BIT] &
        ~(do_write && wlane0_r && widx == `TSLC_IDX_STATUS && wbyte[`TSLC_STAT_GRP_BIT])) |
        ((|gesture_evt) && sample_en[NUM_BUTTONS]); // [RULE2]
      grp_stat_r <= (grp_stat_r & ~((do_write && wlane0_r && widx == `TSLC_IDX_GRP_STATUS) ? wbyte[4:0] : 5'h00)) |
        {(sample_en[NUM_BUTTONS] ? gesture_evt : 3'h0), mt_evt_r,
        (lid_cfg_r[`TSLC_LID_EN_BIT] && lid_match)}; // [RULE2] [RULE11] [RULE19]
    end
  end

  // interrupt: sampled touches and gestures, and lid events only when enabled
  assign alert = (|touch_stat_r) || (|grp_stat_r[`TSLC_GS_GEST_MSB:`TSLC_GS_GEST_LSB]) ||
    (grp_stat_r[`TSLC_GS_LID_BIT] && lid_cfg_r[`TSLC_LID_IRQ_BIT]); // [RULE2] [RULE3] [RULE14]

  // read data selection
  always_comb
  begin
    rmux = 32'h0;
    rhit = (s_axi_araddr[ADDR_W-1:10] == '0);
    case (ridx)
      `TSLC_IDX_SLEEP_SEL: rmux[7:0] = sleep_sel_r;
      `TSLC_IDX_MULTI: rmux[7:0] = multi_r; // [RULE20]
      `TSLC_IDX_LID_CFG: rmux[7:0] = lid_cfg_r; // [RULE20]
      `TSLC_IDX_QUEUE: rmux[7:0] = queue_r; // [RULE20]
      `TSLC_IDX_PAT1: rmux[7:0] = pat1_r;
      `TSLC_IDX_PAT2: rmux[7:0] = pat2_r;
      `TSLC_IDX_STATUS: rmux[7:0] = touch_stat_r;
      `TSLC_IDX_GRP_STATUS: rmux[4:0] = grp_stat_r; // [RULE19]
      `TSLC_IDX_LID_STATUS: rmux[NUM_SENSORS-1:0] = lid_status;
      default: rhit = 1'b0;
    endcase
  end

  // read channel: one outstanding read, data registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= tslc_pkg::TSLC_RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rhit ? rmux : 32'h0;
      rresp_r <= rhit ? tslc_pkg::TSLC_RESP_OKAY : tslc_pkg::TSLC_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule : tslc_top

// ### tb/tb.sv
// self-checking bench of the touch sleep/lid block
`timescale 1ns/1ps
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, sleep = 1'b0, go = 1'b0, e;
  logic [31:0] wd = 32'h0, rd, v, seed = 32'h81F15392;
  logic [3:0] ws = 4'hF;
  logic [2:0] gest = 3'h0;
  logic [1:0] br, rr, resp;
  logic awr, wr, bv, arr, rv, strobe, mte, alert;
  logic [13:0] tv = 14'h0, lv = 14'h0, traw, lraw, sen, sext, tacc, lsts;
  logic [7:0] rst [6] = '{8'h00, 8'h82, 8'h00, 8'h02, 8'h7F, 8'h7F};
  logic [7:0] msk [6] = '{8'hFF, 8'h8F, 8'h83, 8'h07, 8'h7F, 8'h7F};
  logic [7:0] lcf [6] = '{8'h82, 8'h83, 8'h81, 8'h80, 8'h80, 8'h01};
  logic [13:0] lrw [6] = '{14'h0083, 14'h0185, 14'h0060, 14'h0180, 14'h0820, 14'h0185};
  logic lex [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  int fails = 0, samples_checked = 0, cyc = 0, need;
  tslc_top #(.ADDR_W(12), .NUM_SENSORS(14), .NUM_BUTTONS(7)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .sleep_mode(sleep),
    .sample_strobe(strobe), .touch_raw(traw), .lid_raw(lraw), .gesture_evt(gest), .sample_en(sen),
    .sample_extend(sext), .touch_accepted(tacc), .multi_touch_evt(mte), .lid_status(lsts), .alert(alert));
  tslc_front_model u_front (.aclk(aclk), .aresetn(aresetn), .go(go), .touch_in(tv), .lid_in(lv),
    .sample_strobe(strobe), .touch_raw(traw), .lid_raw(lraw));
  // clock and hang limit
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc > 30000)
      complete_run(1);
  end
  // xorshift source and bit run helper
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [13:0] ones(input int n);
    return 14'((1 << n) - 1);
  endfunction : ones
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run(input int extra);
    fails = fails + extra;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // write: address and data offered together, each released when taken
  // ready is offered with the request on odd indices and after the answer on even ones
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    awa <= {2'h0, idx, 2'h0};
    wd <= {24'h0, d};
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= idx[0];
    do
    begin
      @(posedge aclk);
      if (awr === 1'b1)
        awv <= 1'b0;
      if (wr === 1'b1)
        wv <= 1'b0;
      if (bv === 1'b1 && !bry)
        bry <= 1'b1;
    end
    while (bv !== 1'b1 || !bry);
    r = br;
    bry <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    ara <= {2'h0, idx, 2'h0};
    arv <= 1'b1;
    rry <= idx[0];
    do
    begin
      @(posedge aclk);
      if (arr === 1'b1)
        arv <= 1'b0;
      if (rv === 1'b1 && !rry)
        rry <= 1'b1;
    end
    while (rv !== 1'b1 || !rry);
    d = rd;
    r = rr;
    rry <= 1'b0;
  endtask : rd_reg
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    wr_reg(idx, d, 4'hF, resp);
    check(resp, 2'h0);
  endtask : wreg
  task automatic rchk(input logic [7:0] idx, input logic [7:0] x);
    rd_reg(idx, v, resp);
    check(v, {24'h0, x});
    check(resp, 2'h0);
  endtask : rchk
  // one sample through the front end, multiple touch pulse returned
  task automatic samp(input logic [13:0] t, input logic [13:0] l, output logic ev);
    @(posedge aclk);
    go <= 1'b1;
    tv <= t;
    lv <= l;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    #1 ev = mte;
  endtask : samp
  task automatic gesture(input logic [2:0] g);
    @(posedge aclk);
    gest <= g;
    @(posedge aclk);
    gest <= 3'h0;
  endtask : gesture
  // main sequence
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 6; k++)
      rchk(8'h29 + 8'(k), rst[k]);
    rd_reg(8'h30, v, resp);
    check(v, 32'h0);
    check(resp, 2'h2);
    wr_reg(8'h30, 8'hFF, 4'hF, resp);
    check(resp, 2'h2);
    wr_reg(8'h29, 8'hFF, 4'h0, resp);
    rchk(8'h29, 8'h00);
    for (int k = 0; k < 18; k++)
    begin
      v = (k < 6) ? 32'hFF : rnd();
      wreg(8'h29 + 8'(k % 6), v[7:0]);
      rchk(8'h29 + 8'(k % 6), v[7:0] & msk[k % 6]);
    end
    wreg(8'h2B, 8'h00);
    wreg(8'h2A, 8'h0F);
    check(sen, 14'h3FFF);
    for (int k = 0; k < 6; k++)
    begin
      v = (k == 0) ? 32'h3FFF : rnd();
      samp(v[13:0], 14'h0, e);
      check(tacc, v[13:0]);
    end
    for (int c = 0; c < 4; c++)
    begin
      wreg(8'h2A, 8'h80 | 8'(c << 2) | 8'(c));
      samp(14'h0, 14'h0, e);
      samp(ones(c + 1) | (ones(c + 2) << 7), 14'h0, e);
      check(e, 1'b0);
      check(tacc, ones(c + 1) | (ones(c + 2) << 7));
      samp(14'h0, 14'h0, e);
      samp(ones(c + 2), 14'h0, e);
      check(e, 1'b1);
      check(tacc, ones(c + 1));
      samp(14'h0, 14'h0, e);
      samp(ones(c + 3) << 7, 14'h0, e);
      check(e, 1'b1);
      check(tacc, ones(c + 2) << 7);
    end
    wreg(8'h2A, 8'h80);
    samp(14'h0002, 14'h0, e);
    samp(14'h0003, 14'h0, e);
    check(tacc, 14'h0002);
    samp(14'h0001, 14'h0, e);
    check(tacc, 14'h0001);
    wreg(8'h2A, 8'h0C);
    samp(14'h0, 14'h0, e);
    wreg(8'h40, 8'hFF);
    wreg(8'h41, 8'hFF);
    wreg(8'h29, 8'h01);
    @(posedge aclk);
    sleep <= 1'b1;
    gesture(3'h7);
    rchk(8'h41, 8'h00);
    check(sen, 14'h0001);
    wreg(8'h29, 8'h81); // the host recalibrates the added sensors; calibration lies outside this block
    check(sext, 14'h3F80);
    check(sen, 14'h3F81);
    samp(14'h0003, 14'h0, e);
    check(sext, 14'h0);
    rchk(8'h40, 8'h01);
    gesture(3'h5);
    rchk(8'h41, 8'h14);
    check(alert, 1'b1);
    @(posedge aclk);
    sleep <= 1'b0;
    samp(14'h0, 14'h0, e);
    wreg(8'h40, 8'hFF);
    wreg(8'h41, 8'hFF);
    for (int q = 0; q < 4; q++)
    begin
      need = (q == 0) ? 1 : q;
      wreg(8'h2C, 8'(q));
      for (int n = 1; n <= need; n++)
      begin
        samp(14'h0, (n == 1) ? 14'h0001 : 14'h2001, e);
        check(lsts, (n < need) ? 14'h0 : 14'h0001);
      end
      for (int n = 1; n <= need; n++)
      begin
        samp(14'h0, 14'h0, e);
        check(lsts, (n < need) ? 14'h0001 : 14'h0);
      end
    end
    wreg(8'h2C, 8'h00);
    wreg(8'h2D, 8'h05);
    wreg(8'h2E, 8'h03);
    for (int k = 0; k < 6; k++)
    begin
      wreg(8'h2B, lcf[k]);
      samp(14'h0, lrw[k], e);
      repeat (2) @(posedge aclk);
      rd_reg(8'h41, v, resp);
      check(v[0], lex[k]);
      check(alert, lex[k] & lcf[k][0]);
      samp(14'h0, 14'h0, e);
      wreg(8'h41, 8'h01);
    end
    complete_run(0);
  end
endmodule : tb

// ### tb/tslc_front_model.sv
// sensing front end model: one strobe per request, raw lines churn between samples
`timescale 1ns/1ps
module tslc_front_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request
  input wire logic go,
  input wire logic [13:0] touch_in,
  input wire logic [13:0] lid_in,
  // sensing lines
  output logic sample_strobe,
  output logic [13:0] touch_raw,
  output logic [13:0] lid_raw
);
  // raw values only mean something in the strobe cycle, so they toggle otherwise
  always_ff @(posedge aclk)
  begin
    sample_strobe <= go & aresetn;
    touch_raw <= !aresetn ? 14'h1555 : (go ? touch_in : ~touch_raw);
    lid_raw <= !aresetn ? 14'h2AAA : (go ? lid_in : ~lid_raw);
  end
endmodule : tslc_front_model

// ### tb/tslc_top_asserts.sv
// bound checker of the touch sleep/lid block ports
`timescale 1ns/1ps
module tslc_checker #(
  parameter int ADDR_W = 12,
  parameter int NUM_SENSORS = 14
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // sensing
  input wire logic sleep_mode,
  input wire logic sample_strobe,
  input wire logic [NUM_SENSORS-1:0] touch_raw,
  input wire logic [NUM_SENSORS-1:0] lid_raw,
  input wire logic [NUM_SENSORS-1:0] sample_en,
  input wire logic [NUM_SENSORS-1:0] touch_accepted,
  input wire logic multi_touch_evt,
  input wire logic [NUM_SENSORS-1:0] lid_status
);
  // single clock domain
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // bus answers and holding
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not presented one cycle after address");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  // sample selection
  chk_awake_all_on: assert property (!sleep_mode |-> &sample_en)
    else $error("sensor disabled while awake");
  chk_group_spread: assert property (sleep_mode |-> (&sample_en[NUM_SENSORS-1:7] || !(|sample_en[NUM_SENSORS-1:7])))
    else $error("grouped sensors enabled apart in sleep");
  // touch blocking and events
  chk_accept_subset: assert property (sample_strobe |=> (touch_accepted & ~$past(touch_raw)) == '0)
    else $error("untouched sensor accepted");
  chk_multi_cause: assert property (multi_touch_evt |-> $past(sample_strobe))
    else $error("multiple touch event without a sample");
  // lid queue
  chk_lid_quiet: assert property (!$past(sample_strobe) |-> $stable(lid_status))
    else $error("lid status moved without a sample");
  chk_lid_rise: assert property ((lid_status & ~$past(lid_status) & ~$past(lid_raw)) == '0)
    else $error("lid status set on a low sample");
  chk_lid_fall: assert property ((~lid_status & $past(lid_status) & $past(lid_raw)) == '0)
    else $error("lid status cleared on a high sample");
  // main scenarios
  cov_lid_set: cover property (sample_strobe ##1 $rose(lid_status[0]));
  cov_multi: cover property (multi_touch_evt);
  cov_bad_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
endmodule : tslc_checker

bind tslc_top tslc_checker #(.ADDR_W(ADDR_W), .NUM_SENSORS(NUM_SENSORS)) u_chk (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .sleep_mode, .sample_strobe, .touch_raw, .lid_raw,
  .sample_en, .touch_accepted, .multi_touch_evt, .lid_status
);
